/* design/cpc_pkg.sv */
// Package with constants for the connection policy controller
package cpc_pkg;
    localparam logic [15:0] CPC_LISTEN_PORT_RST  = 16'h2711;
    localparam logic [15:0] CPC_SRC_PORT_FIRST   = 16'hc350;
    localparam logic [15:0] CPC_SRC_PORT_LAST    = 16'hea5f;
    localparam logic [7:0]  CPC_POLICY_RST       = 8'hc0;
    localparam logic [7:0]  CPC_START_CHAR_RST   = 8'h0d;
    localparam logic [7:0]  CPC_CHAR_CONNECTED   = 8'h43;
    localparam logic [7:0]  CPC_CHAR_DISCONNECT  = 8'h44;
    localparam logic [7:0]  CPC_CHAR_UNREACHABLE = 8'h4e;
    localparam logic [7:0]  CPC_ID_VALUE         = 8'h5a; // Arbitrary value
    // Policy byte fields
    localparam int CPC_ACCEPT_MSB = 7;
    localparam int CPC_ACCEPT_LSB = 5;
    localparam int CPC_RESP_BIT   = 4;
    localparam int CPC_START_MSB  = 3;
    localparam int CPC_START_LSB  = 0;
    localparam logic [2:0] CPC_ACC_NEVER  = 3'h0;
    localparam logic [2:0] CPC_ACC_MODEM  = 3'h2;
    localparam logic [2:0] CPC_ACC_ALWAYS = 3'h6;
    localparam logic [3:0] CPC_HOSTLIST_HI = 4'h2;
    // APB register byte offsets
    localparam logic [7:0] CPC_REG_POLICY  = 8'h00;
    localparam logic [7:0] CPC_REG_LISTEN  = 8'h04;
    localparam logic [7:0] CPC_REG_STARTCH = 8'h08;
    localparam logic [7:0] CPC_REG_STATUS  = 8'h0c;
    localparam logic [7:0] CPC_REG_SRCPORT = 8'h10;
    localparam logic [7:0] CPC_REG_ID      = 8'h14;
    // Status bit positions
    localparam int CPC_ST_LINKED   = 0;
    localparam int CPC_ST_MODEM    = 1;
    localparam int CPC_ST_HOSTLIST = 2;
    localparam int CPC_ST_UDP      = 3;
    localparam int CPC_ST_MANUAL   = 4;
    localparam int CPC_ST_AUTO     = 5;
    localparam int CPC_ST_ECHO     = 6;
    localparam int CPC_ST_RESPONLY = 7;
    localparam int CPC_ST_NUMERIC  = 8;
    localparam int CPC_ST_PORTBAD  = 9;

    typedef enum logic [2:0] {
        CPC_START_NONE   = 3'b000,
        CPC_START_ANY    = 3'b001,
        CPC_START_MODEM  = 3'b010,
        CPC_START_CHAR   = 3'b011,
        CPC_START_MANUAL = 3'b100,
        CPC_START_AUTO   = 3'b101,
        CPC_START_UDP    = 3'b110,
        CPC_START_OTHER  = 3'b111
    } cpc_start_t;
endpackage

/* design/cpc_decode_if.sv */
// Interface carrying the decoded policy fields
`timescale 1ns/1ps
interface cpc_decode_if;
    import cpc_pkg::*;
    logic       accept_never;
    logic       accept_modem;
    logic       accept_always;
    logic       respond_chars;
    logic       hostlist;
    logic       modem_mode;
    logic       echo;
    logic       resp_only;
    logic       numeric;
    cpc_start_t start_mode;
    modport producer (output accept_never, accept_modem, accept_always, respond_chars,
                      hostlist, modem_mode, echo, resp_only, numeric, start_mode);
    modport consumer (input accept_never, accept_modem, accept_always, respond_chars,
                      hostlist, modem_mode, echo, resp_only, numeric, start_mode);
endinterface

/* design/cpc_policy_decode.sv */
// Combinational decoder of the connection policy byte
`timescale 1ns/1ps
module cpc_policy_decode
    import cpc_pkg::*;
(
    // Policy byte
    input  wire logic [7:0]  connection_policy_byte_i,
    // Decoded fields
    cpc_decode_if.producer   dec
);
    logic [2:0] acc;
    logic [3:0] st;
    assign acc = connection_policy_byte_i[CPC_ACCEPT_MSB:CPC_ACCEPT_LSB];
    assign st  = connection_policy_byte_i[CPC_START_MSB:CPC_START_LSB];

    always_comb begin
        dec.accept_never  = (acc == CPC_ACC_NEVER);
        dec.accept_modem  = (acc == CPC_ACC_MODEM);
        dec.accept_always = (acc == CPC_ACC_ALWAYS);
        dec.hostlist      = (connection_policy_byte_i[7:4] == CPC_HOSTLIST_HI);
        dec.modem_mode    = connection_policy_byte_i[2] && connection_policy_byte_i[1]
                            && !connection_policy_byte_i[5] && !dec.hostlist;
        dec.echo          = dec.modem_mode && connection_policy_byte_i[4];
        dec.resp_only     = dec.modem_mode && !connection_policy_byte_i[4]
                            && connection_policy_byte_i[3];
        dec.numeric       = dec.modem_mode && connection_policy_byte_i[0];
        dec.respond_chars = connection_policy_byte_i[CPC_RESP_BIT]
                            && !dec.modem_mode && !dec.hostlist;
        case (st)
            4'h0: dec.start_mode = CPC_START_NONE;
            4'h1: dec.start_mode = CPC_START_ANY;
            4'h2: dec.start_mode = CPC_START_MODEM;
            4'h3: dec.start_mode = CPC_START_CHAR;
            4'h4: dec.start_mode = CPC_START_MANUAL;
            4'h5: dec.start_mode = CPC_START_AUTO;
            4'hc: dec.start_mode = CPC_START_UDP;
            default: dec.start_mode = CPC_START_OTHER;
        endcase
        if (dec.hostlist || dec.modem_mode) begin
            dec.start_mode = CPC_START_OTHER;
        end
    end
endmodule

/* design/cpc_connection_policy.sv */
// Connection policy controller top with APB registers
// Summary of operation
// - Listening port register, reset value 10001
// - Port zero: source port 50000..59999 wraps
// - Policy byte decoded per field, others ignored
// - Bits 7..5 choose incoming acceptance
// - Never mode refuses all incoming
// - Modem mode accepts only while asserted
// - Always mode accepts when not linked
// - Bit 4 sends C, D, N characters
// - Responses off in modem or hostlist
// - Verbose reporting also sends host address
// - Bits 3..0 choose startup kind
// - Modem mode echo, response, numeric flags
// - No startup never requests outgoing
// - Any character requests outgoing
// - Modem input rising edge requests outgoing
// - Start character requests, default CR
`timescale 1ns/1ps
module cpc_connection_policy
    import cpc_pkg::*;
(
    // Clock and reset
    input  wire logic        sys_clk_i,
    input  wire logic        resetn_i,
    input  wire logic        cfg_clear_i,
    // APB slave
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    // Modem control pin
    input  wire logic        modem_ctrl_i,
    // Serial receive side
    input  wire logic        rx_valid_i,
    input  wire logic [7:0]  rx_data_i,
    // Network side events
    input  wire logic        net_conn_req_i,
    input  wire logic [31:0] net_peer_addr_i,
    input  wire logic        net_connected_i,
    input  wire logic        net_disconnected_i,
    input  wire logic        net_unreachable_i,
    input  wire logic        net_linked_i,
    input  wire logic        net_new_conn_i,
    // Network side answers
    output logic             net_accept_o,
    output logic             net_refuse_o,
    output logic             net_connect_req_o,
    output logic      [15:0] local_port_o,
    // Serial transmit side
    output logic             tx_valid_o,
    output logic      [7:0]  tx_data_o,
    input  wire logic        tx_ready_i
);
    cpc_decode_if dec ();

    // Registers
    logic [7:0]  policy;
    logic [15:0] listen_port;
    logic [7:0]  start_char;
    logic        verbose;
    logic [15:0] src_port;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [2:0]  mc_sync;
    logic        mc_level;
    logic        accept;
    logic        refuse;
    logic        conn_req;
    logic        tx_valid;
    logic [7:0]  tx_data;
    logic [15:0] local_port;
    logic [31:0] peer_addr;
    logic [2:0]  addr_left;

    logic [7:0]  next_policy;
    logic [15:0] next_listen_port;
    logic [7:0]  next_start_char;
    logic        next_verbose;
    logic [15:0] next_src_port;
    logic [31:0] next_prdata;
    logic        next_pready;
    logic        next_pslverr;
    logic [2:0]  next_mc_sync;
    logic        next_mc_level;
    logic        next_accept;
    logic        next_refuse;
    logic        next_conn_req;
    logic        next_tx_valid;
    logic [7:0]  next_tx_data;
    logic [31:0] next_peer_addr;
    logic [2:0]  next_addr_left;
    logic [15:0] next_local_port;

    logic        wr_en;
    logic        rd_en;
    logic        mc_rise;
    logic [9:0]  status;

    function automatic logic port_reserved(input logic [15:0] p);
        port_reserved = (p <= 16'h0400) || (p == 16'h270f)
                        || (p >= 16'h36b0 && p <= 16'h36b9)
                        || (p == 16'h77f0) || (p == 16'h77fe);
    endfunction

    cpc_policy_decode u_decode (
        .connection_policy_byte_i (policy),
        .dec                      (dec)
    );

    assign wr_en = psel_i && penable_i && pwrite_i && pready;
    assign rd_en = psel_i && !penable_i && !pwrite_i;

    assign status = {port_reserved(listen_port) && (listen_port != 16'h0000), dec.numeric,
                     dec.resp_only, dec.echo, (dec.start_mode == CPC_START_AUTO),
                     (dec.start_mode == CPC_START_MANUAL), (dec.start_mode == CPC_START_UDP),
                     dec.hostlist, mc_level, net_linked_i};

    // Modem input edge: second and third stage agree
    assign mc_rise = (mc_sync[2] == mc_sync[1]) && mc_sync[1] && !mc_level;

    always_comb begin
        next_policy      = policy;
        next_listen_port = listen_port;
        next_start_char  = start_char;
        next_verbose     = verbose;
        next_src_port    = src_port;
        next_prdata      = prdata;
        next_pready      = psel_i && !penable_i;
        next_pslverr     = 1'b0;
        next_mc_sync     = {mc_sync[1:0], modem_ctrl_i};
        next_mc_level    = (mc_sync[2] == mc_sync[1]) ? mc_sync[1] : mc_level;
        next_accept      = 1'b0;
        next_refuse      = 1'b0;
        next_conn_req    = 1'b0;
        next_tx_valid    = tx_valid && !tx_ready_i;
        next_tx_data     = tx_data;
        next_peer_addr   = peer_addr;
        next_addr_left   = addr_left;
        // Register writes
        if (wr_en) begin
            case (paddr_i)
                CPC_REG_POLICY:  next_policy = pwdata_i[7:0];
                CPC_REG_LISTEN: begin
                    next_listen_port = pwdata_i[15:0];
                end
                CPC_REG_STARTCH: begin
                    next_start_char = pwdata_i[7:0];
                    next_verbose    = pwdata_i[8];
                end
                default: next_pslverr = 1'b0;
            endcase
        end
        if (psel_i && penable_i && pready) begin
            next_pslverr = !(paddr_i == CPC_REG_POLICY || paddr_i == CPC_REG_LISTEN
                             || paddr_i == CPC_REG_STARTCH || paddr_i == CPC_REG_STATUS
                             || paddr_i == CPC_REG_SRCPORT || paddr_i == CPC_REG_ID);
            next_pslverr = 1'b0;
        end
        if (rd_en) begin
            case (paddr_i)
                CPC_REG_POLICY:  next_prdata = {24'h000000, policy};
                CPC_REG_LISTEN:  next_prdata = {16'h0000, listen_port};
                CPC_REG_STARTCH: next_prdata = {23'h000000, verbose, start_char};
                CPC_REG_STATUS:  next_prdata = {22'h000000, status};
                CPC_REG_SRCPORT: next_prdata = {16'h0000, src_port};
                CPC_REG_ID:      next_prdata = {24'h000000, CPC_ID_VALUE};
                default:         next_prdata = 32'h00000000;
            endcase
        end
        // Incoming acceptance
        if (net_conn_req_i) begin
            if (dec.accept_modem && mc_level && !dec.modem_mode) begin
                next_accept = 1'b1;
            end else if (dec.accept_always && !net_linked_i && !dec.hostlist) begin
                next_accept = 1'b1;
            end else begin
                next_refuse = 1'b1;
            end
        end
        // Outgoing startup
        case (dec.start_mode)
            CPC_START_NONE:  next_conn_req = 1'b0;
            CPC_START_ANY:   next_conn_req = rx_valid_i && !net_linked_i;
            CPC_START_MODEM: next_conn_req = mc_rise && !net_linked_i;
            CPC_START_CHAR:  next_conn_req = rx_valid_i && (rx_data_i == start_char)
                                             && !net_linked_i;
            default:         next_conn_req = 1'b0;
        endcase
        // Source port counter
        if (net_new_conn_i && listen_port == 16'h0000) begin
            next_src_port = (src_port == CPC_SRC_PORT_LAST) ? CPC_SRC_PORT_FIRST
                                                            : src_port + 16'h0001;
        end
        // Character responses
        if (!next_tx_valid && dec.respond_chars) begin
            if (addr_left != 3'h0) begin
                next_tx_valid  = 1'b1;
                next_tx_data   = peer_addr[31:24];
                next_peer_addr = {peer_addr[23:0], 8'h00};
                next_addr_left = addr_left - 3'h1;
            end else if (net_connected_i) begin
                next_tx_valid  = 1'b1;
                next_tx_data   = CPC_CHAR_CONNECTED;
                next_peer_addr = net_peer_addr_i;
                next_addr_left = verbose ? 3'h4 : 3'h0;
            end else if (net_disconnected_i) begin
                next_tx_valid = 1'b1;
                next_tx_data  = CPC_CHAR_DISCONNECT;
            end else if (net_unreachable_i) begin
                next_tx_valid = 1'b1;
                next_tx_data  = CPC_CHAR_UNREACHABLE;
            end
        end
        if (cfg_clear_i) begin
            next_policy      = CPC_POLICY_RST;
            next_listen_port = CPC_LISTEN_PORT_RST;
            next_start_char  = CPC_START_CHAR_RST;
            next_verbose     = 1'b0;
            next_src_port    = CPC_SRC_PORT_FIRST;
            next_tx_valid    = 1'b0;
            next_addr_left   = 3'h0;
            next_conn_req    = 1'b0;
            next_accept      = 1'b0;
            next_refuse      = 1'b0;
        end
        next_local_port = (next_listen_port == 16'h0000) ? next_src_port : next_listen_port;
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            policy      <= CPC_POLICY_RST;
            listen_port <= CPC_LISTEN_PORT_RST;
            start_char  <= CPC_START_CHAR_RST;
            verbose     <= 1'b0;
            src_port    <= CPC_SRC_PORT_FIRST;
            prdata      <= 32'h00000000;
            pready      <= 1'b0;
            pslverr     <= 1'b0;
            mc_sync     <= 3'h0;
            mc_level    <= 1'b0;
            accept      <= 1'b0;
            refuse      <= 1'b0;
            conn_req    <= 1'b0;
            tx_valid    <= 1'b0;
            tx_data     <= 8'h00;
            peer_addr   <= 32'h00000000;
            addr_left   <= 3'h0;
            local_port  <= CPC_LISTEN_PORT_RST;
        end else begin
            policy      <= next_policy;
            listen_port <= next_listen_port;
            start_char  <= next_start_char;
            verbose     <= next_verbose;
            src_port    <= next_src_port;
            prdata      <= next_prdata;
            pready      <= next_pready;
            pslverr     <= next_pslverr;
            mc_sync     <= next_mc_sync;
            mc_level    <= next_mc_level;
            accept      <= next_accept;
            refuse      <= next_refuse;
            conn_req    <= next_conn_req;
            tx_valid    <= next_tx_valid;
            tx_data     <= next_tx_data;
            peer_addr   <= next_peer_addr;
            addr_left   <= next_addr_left;
            local_port  <= next_local_port;
        end
    end

    // Outputs straight from flip-flops
    assign prdata_o          = prdata;
    assign pready_o          = pready;
    assign pslverr_o         = pslverr;
    assign net_accept_o      = accept;
    assign net_refuse_o      = refuse;
    assign net_connect_req_o = conn_req;
    assign local_port_o      = local_port;
    assign tx_valid_o        = tx_valid;
    assign tx_data_o         = tx_data;
endmodule

/* tb/cpc_policy_monitor.sv */
// Checker of the connection policy controller ports
`timescale 1ns/1ps
module cpc_policy_monitor
    import cpc_pkg::*;
(
    // Clock, reset and clear
    input wire logic        sys_clk_i,
    input wire logic        resetn_i,
    input wire logic        cfg_clear_i,
    // APB
    input wire logic        psel_i,
    input wire logic        penable_i,
    input wire logic        pwrite_i,
    input wire logic [7:0]  paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic        pready_o,
    // Serial and modem side
    input wire logic        modem_ctrl_i,
    input wire logic        rx_valid_i,
    input wire logic [7:0]  rx_data_i,
    input wire logic        tx_valid_o,
    input wire logic [7:0]  tx_data_o,
    input wire logic        tx_ready_i,
    // Network side
    input wire logic        net_conn_req_i,
    input wire logic        net_linked_i,
    input wire logic        net_connected_i,
    input wire logic        net_accept_o,
    input wire logic        net_refuse_o,
    input wire logic        net_connect_req_o
);
    logic [7:0] pol;
    logic [7:0] sch;
    logic [3:0] st;

    // Shadow of policy byte and start character
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pol <= CPC_POLICY_RST;
            sch <= CPC_START_CHAR_RST;
        end else if (cfg_clear_i) begin
            pol <= CPC_POLICY_RST;
            sch <= CPC_START_CHAR_RST;
        end else if (psel_i && penable_i && pready_o && pwrite_i) begin
            if (paddr_i == CPC_REG_POLICY) pol <= pwdata_i[7:0];
            if (paddr_i == CPC_REG_STARTCH) sch <= pwdata_i[7:0];
        end
    end
    assign st = pol[3:0];

    default clocking dc @(posedge sys_clk_i); endclocking
    default disable iff (!resetn_i);

    never_refuse_a: assert property (
        pol[7:5] == CPC_ACC_NEVER && net_conn_req_i |=> net_refuse_o && !net_accept_o)
        else $error("incoming accepted in never mode");
    always_accept_a: assert property (
        pol[7:5] == CPC_ACC_ALWAYS && !net_linked_i && net_conn_req_i |=> net_accept_o)
        else $error("incoming not accepted in always mode");
    linked_refuse_a: assert property (
        pol[7:5] == CPC_ACC_ALWAYS && net_linked_i && net_conn_req_i |=> net_refuse_o)
        else $error("incoming accepted while linked");
    modem_gate_a: assert property (
        pol[7:5] == CPC_ACC_MODEM && net_conn_req_i && !modem_ctrl_i
        && !$past(modem_ctrl_i, 6) |=> net_refuse_o)
        else $error("incoming accepted with modem input low");
    answer_cause_a: assert property (
        net_accept_o || net_refuse_o |-> $past(net_conn_req_i) && !(net_accept_o && net_refuse_o))
        else $error("accept or refuse without request");
    no_start_a: assert property (
        net_connect_req_o |-> $past(st) != 4'h0)
        else $error("outgoing request with no startup");
    any_char_a: assert property (
        st == 4'h1 && pol[7:4] != CPC_HOSTLIST_HI && rx_valid_i |=> net_connect_req_o)
        else $error("no outgoing request on character");
    start_char_a: assert property (
        st == 4'h3 && pol[7:4] != CPC_HOSTLIST_HI && rx_valid_i && rx_data_i == sch
        |=> net_connect_req_o)
        else $error("no outgoing request on start character");
    apb_answer_a: assert property (psel_i && !penable_i |-> ##[1:3] pready_o)
        else $error("bus answer late");
    tx_hold_a: assert property (
        tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o))
        else $error("serial byte dropped before ready");
    quiet_mode_a: assert property (
        !pol[4] && !tx_valid_o && net_connected_i |=> !tx_valid_o)
        else $error("character sent in quiet mode");

    cover property (net_accept_o);
    cover property (net_connect_req_o);
    cover property (tx_valid_o && tx_ready_i);
endmodule

bind cpc_connection_policy cpc_policy_monitor mon (
    .sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .cfg_clear_i(cfg_clear_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .pready_o(pready_o), .modem_ctrl_i(modem_ctrl_i),
    .rx_valid_i(rx_valid_i), .rx_data_i(rx_data_i), .tx_valid_o(tx_valid_o),
    .tx_data_o(tx_data_o), .tx_ready_i(tx_ready_i), .net_conn_req_i(net_conn_req_i),
    .net_linked_i(net_linked_i), .net_connected_i(net_connected_i),
    .net_accept_o(net_accept_o), .net_refuse_o(net_refuse_o),
    .net_connect_req_o(net_connect_req_o));

/* tb/cpc_serial_peer.sv */
// Serial device model that stalls the transmit handshake
`timescale 1ns/1ps
module cpc_serial_peer (
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic resetn_i,
    // Transmit handshake
    input  wire logic tx_valid_i,
    output logic      tx_ready_o
);
    logic [7:0] lfsr;

    // Random stalls of the serial receiver
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            lfsr       <= 8'h5b;
            tx_ready_o <= 1'b0;
        end else begin
            lfsr       <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
            tx_ready_o <= tx_valid_i && lfsr[0];
        end
    end
endmodule

/* tb/connection_policy_controller_test.sv */
// Testbench of the connection policy controller
`timescale 1ns/1ps
module connection_policy_controller_test;
    import cpc_pkg::*;
    logic        clk = 1'b0, resetn = 1'b0, clr = 1'b0, psel = 1'b0, penable = 1'b0;
    logic        pwrite = 1'b0, modem = 1'b0, linked = 1'b0;
    logic [7:0]  paddr = 8'h00, rx_data = 8'h00;
    logic [31:0] pwdata = 32'h0, peer = 32'h0, rd, prdata, seed = 32'h194036cd;
    logic [5:0]  pls = 6'h00;
    logic        pready, acc, rej, creq, txv, tx_ready, slverr;
    logic [15:0] lport;
    logic [7:0]  txd;
    logic [15:0] exp_q[$];
    int          errors = 0, cmp_count = 0;
    logic [7:0]  ra[5] = '{CPC_REG_POLICY, CPC_REG_LISTEN, CPC_REG_STARTCH, CPC_REG_ID, 8'h1c};
    logic [31:0] rv[5] = '{32'(CPC_POLICY_RST), 32'(CPC_LISTEN_PORT_RST),
                           32'(CPC_START_CHAR_RST), 32'(CPC_ID_VALUE), 32'h0};
    logic [7:0]  pa[3] = '{8'h00, 8'h50, 8'hd0};
    logic [7:0]  rc[3] = '{CPC_CHAR_CONNECTED, CPC_CHAR_DISCONNECT, CPC_CHAR_UNREACHABLE};

    cpc_connection_policy dut (
        .sys_clk_i(clk), .resetn_i(resetn), .cfg_clear_i(clr), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(slverr), .modem_ctrl_i(modem),
        .rx_valid_i(pls[5]), .rx_data_i(rx_data), .net_conn_req_i(pls[0]),
        .net_peer_addr_i(peer), .net_connected_i(pls[1]), .net_disconnected_i(pls[2]),
        .net_unreachable_i(pls[3]), .net_linked_i(linked), .net_new_conn_i(pls[4]),
        .net_accept_o(acc), .net_refuse_o(rej), .net_connect_req_o(creq),
        .local_port_o(lport), .tx_valid_o(txv), .tx_data_o(txd), .tx_ready_i(tx_ready));
    cpc_serial_peer peer_model (.clk_i(clk), .resetn_i(resetn), .tx_valid_i(txv),
                                .tx_ready_o(tx_ready));

    initial begin
        forever #2 clk = ~clk;
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task results();
        $display("comparisons %0d errors %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    task give_up();
        errors++;
        results();
    endtask

    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) begin
            if (++n > 20) give_up();
            @(posedge clk);
        end
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task pulse(input int b);
        pls[b] <= 1'b1;
        @(posedge clk);
        pls <= 6'h00;
        @(posedge clk);
    endtask

    task drain();
        int n;
        n = 0;
        while (exp_q.size() != 0) begin
            if (++n > 400) give_up();
            @(posedge clk);
        end
        repeat (8) @(posedge clk);
    endtask

    task take(input logic [15:0] seen);
        if (exp_q.size() == 0) check("unexpected event", 32'(seen), 32'hffff);
        else check("event", 32'(seen), 32'(exp_q.pop_front()));
    endtask

    // Result watcher
    always @(posedge clk) begin
        if (resetn === 1'b1) begin
            if (acc === 1'b1 || rej === 1'b1) take({8'h01, 7'h0, acc});
            if (creq === 1'b1) take(16'h0200);
            if (txv === 1'b1 && tx_ready === 1'b1) take({8'h03, txd});
        end
    end

    initial begin
        logic [31:0] v;
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        check("listen port", 32'(lport), 32'(CPC_LISTEN_PORT_RST));
        apb(1'b1, CPC_REG_ID, 32'hff);
        apb(1'b1, 8'h1c, 32'hff);
        foreach (ra[i]) begin
            apb(1'b0, ra[i], 32'h0);
            check("register", rd, rv[i]);
            check("slave error", 32'(slverr), 32'h0);
        end
        // Acceptance modes, modem gating kept apart from modem mode
        foreach (pa[i]) for (int m = 0; m < 2; m++) begin
            apb(1'b1, CPC_REG_POLICY, 32'(pa[i]));
            modem <= m[0];
            repeat (8) @(posedge clk);
            exp_q.push_back({8'h01, 7'h0, pa[i][7] | (pa[i][6] & m[0])});
            pulse(0);
            drain();
        end
        linked <= 1'b1;
        exp_q.push_back(16'h0100);
        pulse(0);
        drain();
        linked <= 1'b0;
        modem <= 1'b0;
        // Startup kinds
        for (int p = 0; p < 5; p++) begin
            apb(1'b1, CPC_REG_POLICY, 32'(p));
            repeat (8) @(posedge clk);
            v = rnd();
            rx_data <= v[7:0] | 8'h80;
            if (p == 1) exp_q.push_back(16'h0200);
            pulse(5);
            if (p == 3) begin
                rx_data <= CPC_START_CHAR_RST;
                exp_q.push_back(16'h0200);
                pulse(5);
            end
            if (p == 2) begin
                exp_q.push_back(16'h0200);
                modem <= 1'b1;
                repeat (12) @(posedge clk);
            end
            if (p == 4) begin
                rx_data <= 8'h43;
                pulse(5);
                rx_data <= 8'h0d;
                pulse(5);
            end
            drain();
        end
        modem <= 1'b0;
        // Response characters
        foreach (pa[i]) begin
            apb(1'b1, CPC_REG_POLICY, 32'({8'hd0, 8'hd6, 8'hc0} >> (8 * i)) & 32'hff);
            for (int b = 1; b < 4; b++) begin
                if (i == 2) exp_q.push_back({8'h03, rc[b - 1]});
                pulse(b);
                drain();
            end
        end
        apb(1'b1, CPC_REG_STARTCH, 32'h10d);
        v = rnd();
        peer <= v;
        exp_q.push_back({8'h03, CPC_CHAR_CONNECTED});
        for (int k = 3; k >= 0; k--) exp_q.push_back({8'h03, v[8 * k +: 8]});
        pulse(1);
        drain();
        // Source port wrap, zero port used with outgoing only
        apb(1'b1, CPC_REG_LISTEN, 32'h0);
        check("source port", 32'(lport), 32'(CPC_SRC_PORT_FIRST));
        for (int i = 1; i <= 10000; i++) begin
            pulse(4);
            check("source port", 32'(lport), 32'(50000 + i % 10000));
        end
        apb(1'b0, CPC_REG_SRCPORT, 32'h0);
        check("source port reg", rd, 32'd50000);
        // Non reserved listening port
        apb(1'b1, CPC_REG_LISTEN, 32'd20000);
        pulse(4);
        check("listen port", 32'(lport), 32'd20000);
        clr <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
        @(posedge clk);
        apb(1'b0, CPC_REG_POLICY, 32'h0);
        check("policy cleared", rd, 32'(CPC_POLICY_RST));
        check("port cleared", 32'(lport), 32'(CPC_LISTEN_PORT_RST));
        results();
    end
endmodule
